// ---- tas_defines.svh ----
// Register map, field positions and reset values of the TDM audio port.
// Assumes byte addresses on an AXI4-Lite bus with 32-bit data.
// Notes on behaviour
// - Eight transmit and eight receive channels, independent.
// - Pins: data out, data in, bclk, frame.
// - Master drives both clocks; slave receives them.
// - Formats DSP A, DSP B, I2S, left-justified.
// - Left-justified and DSP B need full master.
// - Samples travel most significant bit first.
// - Samples are signed two's complement words.
// - DSP MSB: edge one (B) or two (A).
// - DSP slots back to back, spare cycles last.
// - I2S MSB on second edge after transition.
// - Left-justified MSB on first edge after transition.
// - Bit and frame clocks invert independently.
// - One stereo pair uses slots zero and one.
// - All channels share one sample rate.
// - Per-channel enables, one slot per channel.
// - DSP slots consecutive; I2S/LJ even first half.
// - Slot length and word length are configurable.
// - Data output may tristate when idle.
// - Master clocks run only with channels enabled.
// - Data words up to 32 bits.
`ifndef TAS_DEFINES_SVH
`define TAS_DEFINES_SVH

`define TAS_AW 8
`define TAS_NCH_MAX 8
`define TAS_WORD_W 32

`define TAS_OFF_CTRL 8'h00
`define TAS_OFF_FRAME 8'h04
`define TAS_OFF_DIV 8'h08
`define TAS_OFF_CHEN 8'h0c
`define TAS_OFF_TXSLOT 8'h10
`define TAS_OFF_RXSLOT 8'h14
`define TAS_OFF_STATUS 8'h18
`define TAS_OFF_TXD0 8'h20
`define TAS_OFF_RXD0 8'h40

`define TAS_B_BMSTR 0
`define TAS_B_FMSTR 1
`define TAS_B_BINV 2
`define TAS_B_FINV 3
`define TAS_F_FMT 5:4
`define TAS_B_TRI 6
`define TAS_F_SLEN 7:0
`define TAS_F_WLEN 13:8
`define TAS_F_FLEN 25:16
`define TAS_F_DIV 7:0
`define TAS_F_TXEN 7:0
`define TAS_F_RXEN 15:8
`define TAS_B_RUN 0
`define TAS_B_REFUSED 1
`define TAS_F_FRESH 15:8
`define TAS_F_OVR 23:16
`define TAS_STRB_OVR 2

`define TAS_MSK_CTRL 32'h0000_007f
`define TAS_MSK_FRAME 32'h03ff_3fff
`define TAS_MSK_DIV 32'h0000_00ff
`define TAS_MSK_CHEN 32'h0000_ffff
`define TAS_MSK_ALL 32'hffff_ffff

`define TAS_RST_CTRL 32'h0000_0000
`define TAS_RST_FRAME 32'h0040_1820
`define TAS_RST_DIV 32'h0000_0004
`define TAS_DIV_MIN 8'h02

`define TAS_RESP_OK 2'h0
`define TAS_RESP_ERR 2'h2

`endif

// ---- tas_pkg.sv ----
// Types shared by the TDM audio port modules.
// Assumes the constants of tas_defines.svh.
package tas_pkg;

	typedef enum logic [1:0] {
		FMT_DSPA,
		FMT_DSPB,
		FMT_I2S,
		FMT_LJ
	} tas_fmt_e;

	typedef struct packed {
		logic bclk_mstr;
		logic frm_mstr;
		logic bclk_inv;
		logic frm_inv;
		tas_fmt_e fmt;
		logic tri_en;
		logic [7:0] slot_len;
		logic [5:0] word_len;
		logic [9:0] frame_len;
		logic [7:0] div;
	} tas_cfg_s;

	typedef struct packed {
		logic act;
		logic [3:0] slot;
		logic [7:0] bis;
	} tas_pos_s;

endpackage : tas_pkg

// ---- tas_sync.sv ----
// Two-stage synchroniser for levels from outside the system clock.
// Assumes the inputs may change at any moment.
`timescale 1ns/1ns
module tas_sync #(
	parameter int W = 1
) (
	// Clock, reset and enable.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Levels.
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else if (ce_i) begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : tas_sync

// ---- tas_clkgen.sv ----
// Bit clock divider and frame clock generator for master operation.
// Assumes fall_i marks falling edges of the normalised bit clock.
`include "tas_defines.svh"
`timescale 1ns/1ns
module tas_clkgen (
	// Clock, reset and enable.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Control.
	input wire logic run_i,
	input tas_pkg::tas_cfg_s cfg_i,
	input wire logic fall_i,
	// Normalised clocks.
	output logic bclk_o,
	output logic frame_o
);

	logic [7:0] div_q;
	logic [9:0] fcnt_q;
	logic [9:0] fnext;

	function automatic logic frame_lvl(tas_pkg::tas_fmt_e f,
		logic [9:0] c, logic [9:0] len);
		case (f)
			tas_pkg::FMT_I2S: frame_lvl = (c >= (len >> 1));
			tas_pkg::FMT_LJ: frame_lvl = (c < (len >> 1));
			default: frame_lvl = (c == 10'h000);
		endcase
	endfunction : frame_lvl

	assign fnext = (fcnt_q >= cfg_i.frame_len - 10'h001) ?
		10'h000 : fcnt_q + 10'h001;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_q <= 8'h00;
			bclk_o <= 1'b0;
		end else if (ce_i) begin
			if (!run_i || !cfg_i.bclk_mstr) begin
				div_q <= 8'h00;
				bclk_o <= 1'b0;
			end else if (div_q >= cfg_i.div - 8'h01) begin
				div_q <= 8'h00;
				bclk_o <= ~bclk_o;
			end else begin
				div_q <= div_q + 8'h01;
			end
		end
	end

	// The frame clock is counted from bit clock falls, whatever drives it.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fcnt_q <= 10'h000;
			frame_o <= 1'b0;
		end else if (ce_i) begin
			if (!run_i) begin
				fcnt_q <= cfg_i.frame_len - 10'h001;
				frame_o <= 1'b0;
			end else if (fall_i) begin
				fcnt_q <= fnext;
				frame_o <= frame_lvl(cfg_i.fmt, fnext, cfg_i.frame_len);
			end
		end
	end

endmodule : tas_clkgen

// ---- tas_port.sv ----
// TDM audio serial port: AXI4-Lite registers, framing and data pins.
// Assumes pin inputs are asynchronous and AXI runs on clk_sys_i.
`include "tas_defines.svh"
`timescale 1ns/1ns
module tas_port #(
	parameter int NCH = 8
) (
	// Clock, reset and enable.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// AXI4-Lite write channels.
	input wire logic [`TAS_AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read channels.
	input wire logic [`TAS_AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Bit clock pin.
	input wire logic bclk_i,
	output logic bclk_o,
	output logic bclk_oe_o,
	// Frame clock pin.
	input wire logic frame_i,
	output logic frame_o,
	output logic frame_oe_o,
	// Serial data pins.
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o
);

	if (NCH < 1 || NCH > `TAS_NCH_MAX) begin : g_bad_nch
		$error("tas_port: NCH must be 1 to 8");
	end

	localparam logic [7:0] BANK_SZ = 8'(4 * NCH);

	// Registers.
	logic [31:0] ctrl_q, frm_q, div_q, chen_q, txslot_q, rxslot_q;
	logic [31:0] tx_data_q [NCH];
	logic [31:0] rx_data_q [NCH];
	logic [31:0] rx_sh_q [NCH];
	logic [NCH-1:0] fresh_q, ovr_q;

	// Bus state.
	logic aw_full_q, w_full_q, do_wr, rd_take, rd_err;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q, rd_val;
	logic [3:0] w_strb_q;

	// Engine state.
	tas_pkg::tas_cfg_s cfg;
	tas_pkg::tas_pos_s cur_q, nx;
	logic [2:0] pin_s;
	logic cg_bclk, cg_frame, bclk_n, frame_n, bclk_prev_q, tick_q;
	logic rise, fall, f_rise_q, f_trk_q, f_now, evt, dsp, lead, half;
	logic fmt_ok, run, din;
	logic [9:0] cnt_q, p;
	logic [3:0] tx_hit, rx_hit;

	function automatic logic [31:0] merge(logic [31:0] old,
		logic [31:0] nw, logic [3:0] strb, logic [31:0] msk);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		merge = r & msk;
	endfunction : merge

	function automatic logic in_bank(logic [7:0] a, logic [7:0] base);
		in_bank = (a >= base) && ((a - base) < BANK_SZ);
	endfunction : in_bank

	function automatic logic [2:0] bank_idx(logic [7:0] a,
		logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		bank_idx = d[4:2];
	endfunction : bank_idx

	// Lowest enabled channel mapped to slot s wins a double mapping.
	function automatic logic [3:0] find_ch(logic [7:0] en,
		logic [31:0] map, logic [3:0] s);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (en[i] && map[4*i +: 4] == s) begin
				r = {1'b1, 3'(i)};
			end
		end
		find_ch = r;
	endfunction : find_ch

	// Sign-extends the low wl bits of a received word.
	function automatic logic [31:0] sext(logic [31:0] w, logic [5:0] wl);
		logic [5:0] sh;
		sh = 6'd32 - wl;
		sext = $unsigned($signed(w << sh) >>> sh);
	endfunction : sext

	// Configuration view of the registers.
	always_comb begin
		cfg.bclk_mstr = ctrl_q[`TAS_B_BMSTR];
		cfg.frm_mstr = ctrl_q[`TAS_B_FMSTR];
		cfg.bclk_inv = ctrl_q[`TAS_B_BINV];
		cfg.frm_inv = ctrl_q[`TAS_B_FINV];
		cfg.fmt = tas_pkg::tas_fmt_e'(ctrl_q[`TAS_F_FMT]);
		cfg.tri_en = ctrl_q[`TAS_B_TRI];
		cfg.slot_len = frm_q[`TAS_F_SLEN];
		cfg.word_len = frm_q[`TAS_F_WLEN];
		if (cfg.word_len == 6'd0 || cfg.word_len > 6'd32) begin
			cfg.word_len = 6'd32;
		end
		cfg.frame_len = frm_q[`TAS_F_FLEN];
		cfg.div = div_q[`TAS_F_DIV];
		if (cfg.div < `TAS_DIV_MIN) begin
			cfg.div = `TAS_DIV_MIN;
		end
	end

	assign dsp = (cfg.fmt == tas_pkg::FMT_DSPA) ||
		(cfg.fmt == tas_pkg::FMT_DSPB);
	assign fmt_ok = (cfg.fmt == tas_pkg::FMT_DSPA) ||
		(cfg.fmt == tas_pkg::FMT_I2S) ||
		(cfg.bclk_mstr && cfg.frm_mstr);
	assign run = fmt_ok && (|chen_q[`TAS_F_TXEN] || |chen_q[`TAS_F_RXEN]);

	// AXI4-Lite write path.
	assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid_o;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `TAS_RESP_OK;
		end else if (ce_i) begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (aw_addr_q <= `TAS_OFF_STATUS ||
					in_bank(aw_addr_q, `TAS_OFF_TXD0) ||
					in_bank(aw_addr_q, `TAS_OFF_RXD0)) ?
					`TAS_RESP_OK : `TAS_RESP_ERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// Writable registers; status and receive data ignore writes here.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= `TAS_RST_CTRL;
			frm_q <= `TAS_RST_FRAME;
			div_q <= `TAS_RST_DIV;
			chen_q <= 32'h0000_0000;
			txslot_q <= 32'h0000_0000;
			rxslot_q <= 32'h0000_0000;
			for (int i = 0; i < NCH; i++) begin
				tx_data_q[i] <= 32'h0000_0000;
			end
		end else if (ce_i && do_wr) begin
			if (aw_addr_q == `TAS_OFF_CTRL) begin
				ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q, `TAS_MSK_CTRL);
			end else if (aw_addr_q == `TAS_OFF_FRAME) begin
				frm_q <= merge(frm_q, w_data_q, w_strb_q, `TAS_MSK_FRAME);
			end else if (aw_addr_q == `TAS_OFF_DIV) begin
				div_q <= merge(div_q, w_data_q, w_strb_q, `TAS_MSK_DIV);
			end else if (aw_addr_q == `TAS_OFF_CHEN) begin
				chen_q <= merge(chen_q, w_data_q, w_strb_q, `TAS_MSK_CHEN);
			end else if (aw_addr_q == `TAS_OFF_TXSLOT) begin
				txslot_q <= merge(txslot_q, w_data_q, w_strb_q,
					`TAS_MSK_ALL);
			end else if (aw_addr_q == `TAS_OFF_RXSLOT) begin
				rxslot_q <= merge(rxslot_q, w_data_q, w_strb_q,
					`TAS_MSK_ALL);
			end else if (in_bank(aw_addr_q, `TAS_OFF_TXD0)) begin
				tx_data_q[bank_idx(aw_addr_q, `TAS_OFF_TXD0)] <=
					merge(tx_data_q[bank_idx(aw_addr_q, `TAS_OFF_TXD0)],
					w_data_q, w_strb_q, `TAS_MSK_ALL);
			end
		end
	end

	// AXI4-Lite read path.
	assign rd_take = s_axi_arvalid_i && s_axi_arready_o;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (s_axi_araddr_i == `TAS_OFF_CTRL) begin
			rd_val = ctrl_q;
		end else if (s_axi_araddr_i == `TAS_OFF_FRAME) begin
			rd_val = frm_q;
		end else if (s_axi_araddr_i == `TAS_OFF_DIV) begin
			rd_val = div_q;
		end else if (s_axi_araddr_i == `TAS_OFF_CHEN) begin
			rd_val = chen_q;
		end else if (s_axi_araddr_i == `TAS_OFF_TXSLOT) begin
			rd_val = txslot_q;
		end else if (s_axi_araddr_i == `TAS_OFF_RXSLOT) begin
			rd_val = rxslot_q;
		end else if (s_axi_araddr_i == `TAS_OFF_STATUS) begin
			rd_val[`TAS_B_RUN] = run;
			rd_val[`TAS_B_REFUSED] = !fmt_ok;
			rd_val[`TAS_F_FRESH] = 8'(fresh_q);
			rd_val[`TAS_F_OVR] = 8'(ovr_q);
		end else if (in_bank(s_axi_araddr_i, `TAS_OFF_TXD0)) begin
			rd_val = tx_data_q[bank_idx(s_axi_araddr_i, `TAS_OFF_TXD0)];
		end else if (in_bank(s_axi_araddr_i, `TAS_OFF_RXD0)) begin
			rd_val = rx_data_q[bank_idx(s_axi_araddr_i, `TAS_OFF_RXD0)];
		end else begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= `TAS_RESP_OK;
		end else if (ce_i) begin
			if (rd_take) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_val;
				s_axi_rresp_o <= rd_err ? `TAS_RESP_ERR : `TAS_RESP_OK;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// Pin inputs and master clock generation.
	tas_sync #(.W(3)) u_sync (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.async_i({serial_data_in_i, frame_i, bclk_i}),
		.sync_o(pin_s)
	);

	tas_clkgen u_clkgen (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.run_i(run),
		.cfg_i(cfg),
		.fall_i(fall),
		.bclk_o(cg_bclk),
		.frame_o(cg_frame)
	);

	assign bclk_n = cfg.bclk_mstr ? cg_bclk : pin_s[0] ^ cfg.bclk_inv;
	assign frame_n = cfg.frm_mstr ? cg_frame : pin_s[1] ^ cfg.frm_inv;
	assign din = pin_s[2];
	assign rise = bclk_n && !bclk_prev_q;
	assign fall = !bclk_n && bclk_prev_q;

	// A slave frame is known only from the level seen at the last rise.
	assign f_now = cfg.frm_mstr ? frame_n : f_rise_q;
	assign evt = dsp ? (f_now && !f_trk_q) : (f_now ^ f_trk_q);
	assign lead = (cfg.fmt == tas_pkg::FMT_DSPA) ||
		(cfg.fmt == tas_pkg::FMT_I2S);
	assign half = (cfg.fmt == tas_pkg::FMT_I2S) ? f_now : !f_now;

	// Position of the next rising edge within the frame.
	always_comb begin
		if (evt) begin
			p = cfg.frm_mstr ? 10'h000 : 10'h001;
		end else begin
			p = cnt_q + {9'h000, ~&cnt_q};
		end
		nx = cur_q;
		if (p == {9'h000, lead}) begin
			nx.act = 1'b1;
			nx.bis = 8'h00;
			nx.slot = dsp ? 4'h0 : {3'h0, half};
		end else if (evt) begin
			nx.act = 1'b0;
		end else if (cur_q.act) begin
			if (cur_q.bis >= cfg.slot_len - 8'h01) begin
				nx.bis = 8'h00;
				nx.slot = cur_q.slot + (dsp ? 4'h1 : 4'h2);
			end else begin
				nx.bis = cur_q.bis + 8'h01;
			end
		end
	end

	assign tx_hit = find_ch(8'(chen_q[NCH-1:0]), txslot_q, nx.slot);
	assign rx_hit = find_ch(8'(chen_q[8 +: NCH]), rxslot_q, cur_q.slot);

	// One frame counter serves every channel, so all share one rate.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bclk_prev_q <= 1'b0;
			tick_q <= 1'b0;
			f_rise_q <= 1'b0;
			f_trk_q <= 1'b0;
			cnt_q <= 10'h3ff;
			cur_q <= '0;
		end else if (ce_i) begin
			bclk_prev_q <= bclk_n;
			tick_q <= fall;
			if (rise) begin
				f_rise_q <= frame_n;
			end
			if (!run) begin
				cnt_q <= 10'h3ff;
				cur_q.act <= 1'b0;
				f_trk_q <= f_now;
			end else if (tick_q) begin
				cnt_q <= p;
				cur_q <= nx;
				f_trk_q <= f_now;
			end
		end
	end

	// Pin outputs, launched one cycle after each bit clock fall.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bclk_o <= 1'b0;
			bclk_oe_o <= 1'b0;
			frame_o <= 1'b0;
			frame_oe_o <= 1'b0;
			serial_data_out_o <= 1'b0;
			serial_data_out_oe_o <= 1'b0;
		end else if (ce_i) begin
			bclk_o <= cg_bclk ^ cfg.bclk_inv;
			bclk_oe_o <= cfg.bclk_mstr && run;
			frame_o <= cg_frame ^ cfg.frm_inv;
			frame_oe_o <= cfg.frm_mstr && run;
			if (!run) begin
				serial_data_out_o <= 1'b0;
				serial_data_out_oe_o <= 1'b0;
			end else if (tick_q) begin
				serial_data_out_o <= 1'b0;
				if (nx.act && tx_hit[3] && nx.bis < {2'b00, cfg.word_len}) begin
					serial_data_out_o <= tx_data_q[tx_hit[2:0]][5'(cfg.word_len
						- 6'd1 - nx.bis[5:0])];
				end
				serial_data_out_oe_o <= !cfg.tri_en ||
					(nx.act && tx_hit[3]);
			end
		end
	end

	// Receive shifting; a read of a data word clears its fresh flag.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fresh_q <= '0;
			ovr_q <= '0;
			for (int i = 0; i < NCH; i++) begin
				rx_sh_q[i] <= 32'h0000_0000;
				rx_data_q[i] <= 32'h0000_0000;
			end
		end else if (ce_i) begin
			if (rd_take && in_bank(s_axi_araddr_i, `TAS_OFF_RXD0)) begin
				fresh_q[bank_idx(s_axi_araddr_i, `TAS_OFF_RXD0)] <= 1'b0;
			end
			if (do_wr && aw_addr_q == `TAS_OFF_STATUS &&
				w_strb_q[`TAS_STRB_OVR]) begin
				ovr_q <= ovr_q & ~NCH'(w_data_q[`TAS_F_OVR]);
			end
			if (run && rise && cur_q.act && rx_hit[3] &&
				cur_q.bis < {2'b00, cfg.word_len}) begin
				rx_sh_q[rx_hit[2:0]] <= {rx_sh_q[rx_hit[2:0]][30:0], din};
				if (cur_q.bis == {2'b00, cfg.word_len - 6'd1}) begin
					rx_data_q[rx_hit[2:0]] <= sext({rx_sh_q[rx_hit[2:0]][30:0],
						din}, cfg.word_len);
					fresh_q[rx_hit[2:0]] <= 1'b1;
					if (fresh_q[rx_hit[2:0]]) begin
						ovr_q[rx_hit[2:0]] <= 1'b1;
					end
				end
			end
		end
	end

endmodule : tas_port

// ---- tas_port_chk.sv ----
// Concurrent checks on the ports of the TDM audio port.
// Assumes it is bound to tas_port and sees only its ports.
`include "tas_defines.svh"
`timescale 1ns/1ns
module tas_port_chk #(
	parameter int NCH = 8
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Register bus.
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Pins.
	input wire logic bclk_o,
	input wire logic bclk_oe_o,
	input wire logic frame_o,
	input wire logic frame_oe_o,
	input wire logic serial_data_out_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	AST_W_RESP: assert property (s_axi_awvalid_i && s_axi_awready_o &&
		s_axi_wvalid_i && s_axi_wready_o |=> ##1 s_axi_bvalid_o)
		else $error("write response not two cycles after handshake");
	AST_R_RESP: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> s_axi_rvalid_o) else $error("read response late");
	AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read response dropped");
	AST_AR_BLOCK: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> !s_axi_arready_o) else $error("second read accepted");
	AST_AW_BLOCK: assert property (s_axi_awvalid_i && s_axi_awready_o
		|=> !s_axi_awready_o) else $error("second write accepted");
	AST_BRESP_CODE: assert property (s_axi_bvalid_o |->
		s_axi_bresp_o inside {`TAS_RESP_OK, `TAS_RESP_ERR})
		else $error("bad write response code");
	// Both checks hold for either bit clock polarity.
	AST_DOUT_STABLE: assert property (
		bclk_oe_o && $past(bclk_oe_o) && $changed(serial_data_out_o)
		|-> $stable(bclk_o))
		else $error("data changed together with the bit clock");
	AST_FRAME_EDGE: assert property (
		frame_oe_o && $past(frame_oe_o) && bclk_oe_o && $changed(frame_o)
		|-> $stable(bclk_o))
		else $error("frame changed together with the bit clock");
endmodule : tas_port_chk

bind tas_port tas_port_chk #(.NCH(NCH)) u_chk (
	.clk_sys_i,
	.arst_n_i,
	.s_axi_awvalid_i,
	.s_axi_awready_o,
	.s_axi_wvalid_i,
	.s_axi_wready_o,
	.s_axi_bresp_o,
	.s_axi_bvalid_o,
	.s_axi_bready_i,
	.s_axi_arvalid_i,
	.s_axi_arready_o,
	.s_axi_rdata_o,
	.s_axi_rvalid_o,
	.s_axi_rready_i,
	.bclk_o,
	.bclk_oe_o,
	.frame_o,
	.frame_oe_o,
	.serial_data_out_o
);

// ---- tas_far_end.sv ----
// Far-end codec model: DSP A clock master, 16-bit frames, 8-bit slots.
// Assumes the clock stands still while run_i is low.
`timescale 1ns/1ns
module tas_far_end (
	// Control and sent word.
	input wire logic run_i,
	input wire logic [7:0] word_i,
	// Port data output as seen on the wire.
	input wire logic sd_i,
	input wire logic sd_oe_i,
	// Clocks and data toward the port.
	output logic bclk_o,
	output logic frame_o,
	output logic sd_o,
	// Captured slot bits, position 0 at bit 15.
	output logic [15:0] cap_o,
	output logic [15:0] cap_oe_o
);
	int k;
	int p;
	logic d;
	// An idle line shows the inverse of the last bit.
	assign sd_o = run_i ? d : ~d;
	initial begin
		bclk_o = 1'b1;
		frame_o = 1'b0;
		d = 1'b0;
		k = 0;
		cap_o = 16'h0000;
		cap_oe_o = 16'h0000;
		forever begin
			wait (run_i);
			#157;
			bclk_o = 1'b0;
			// The port bit sampled here was launched one period ago.
			cap_o[15 - ((k + 14) % 16)] = sd_i;
			cap_oe_o[15 - ((k + 14) % 16)] = sd_oe_i;
			frame_o = (k == 0);
			p = (k + 15) % 16;
			d = (p < 8) ? word_i[7 - p] : 1'b0;
			k = (k + 1) % 16;
			#163;
			bclk_o = 1'b1;
		end
	end
endmodule : tas_far_end

// ---- tas_port_test.sv ----
// Self-checking bench for the TDM audio port over AXI4-Lite.
// Assumes tas_far_end as link partner and the bound checker.
`include "tas_defines.svh"
`timescale 1ns/1ns
module tas_port_test;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic [7:0] s_axi_awaddr_i = 8'h00;
	logic [7:0] s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic s_axi_awvalid_i = 1'b0;
	logic s_axi_wvalid_i = 1'b0;
	logic s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0;
	logic s_axi_rready_i = 1'b0;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp_q;
	logic [31:0] s_axi_rdata_o, rd_q;
	logic bclk_o, bclk_oe_o, frame_o, frame_oe_o;
	logic serial_data_out_o, serial_data_out_oe_o, serial_data_in_i;
	logic prt_run = 1'b0;
	logic prt_bclk, prt_frame;
	logic [15:0] cap, cap_oe;
	logic [7:0] txw = 8'h3d;
	int n_mismatch = 0;
	int total_checks = 0;
	wire bclk_i = bclk_oe_o ? bclk_o : prt_bclk;
	wire frame_i = frame_oe_o ? frame_o : prt_frame;

	always #20 clk_sys_i = ~clk_sys_i;

	tas_port #(.NCH(8)) dut (.clk_sys_i, .arst_n_i, .ce_i,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
		.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.bclk_i, .bclk_o, .bclk_oe_o, .frame_i, .frame_o, .frame_oe_o,
		.serial_data_in_i, .serial_data_out_o, .serial_data_out_oe_o);

	tas_far_end u_far (.run_i(prt_run), .word_i(8'ha5),
		.sd_i(serial_data_out_o), .sd_oe_i(serial_data_out_oe_o),
		.bclk_o(prt_bclk), .frame_o(prt_frame), .sd_o(serial_data_in_i),
		.cap_o(cap), .cap_oe_o(cap_oe));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_sys_i);
			if (!aw_done && s_axi_awready_o) begin
				aw_done = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (!w_done && s_axi_wready_o) begin
				w_done = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		s_axi_bready_i <= 1'b1;
		do @(posedge clk_sys_i); while (s_axi_bvalid_o !== 1'b1);
		rsp_q = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do @(posedge clk_sys_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		s_axi_rready_i <= 1'b1;
		do @(posedge clk_sys_i); while (s_axi_rvalid_o !== 1'b1);
		rd_q = s_axi_rdata_o;
		rsp_q = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] r);
		rd(a);
		chk(rd_q, exp);
		chk(rsp_q, r);
	endtask : rdc

	// Runs a master format and checks the first slot word bit by bit.
	task automatic mstr(input logic [31:0] ctrl, input logic lvl,
		input int lead);
		wr(`TAS_OFF_CTRL, ctrl);
		wait (frame_o !== lvl);
		wait (frame_o === lvl);
		repeat (lead - 1) @(posedge bclk_o);
		for (int i = 7; i >= 0; i--) begin
			@(posedge bclk_o);
			chk(serial_data_out_o, txw[i]);
		end
		chk({bclk_oe_o, frame_oe_o}, 2'b11);
	endtask : mstr

	task end_of_test;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_mismatch++;
		end_of_test;
	end

	initial begin
		repeat (12) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rdc(`TAS_OFF_CTRL, `TAS_RST_CTRL, `TAS_RESP_OK);
		rdc(`TAS_OFF_FRAME, `TAS_RST_FRAME, `TAS_RESP_OK);
		rdc(`TAS_OFF_DIV, `TAS_RST_DIV, `TAS_RESP_OK);
		rdc(`TAS_OFF_CHEN, 32'h0, `TAS_RESP_OK);
		rdc(8'h1c, 32'h0, `TAS_RESP_ERR);
		wr(8'h1c, 32'h1);
		chk(rsp_q, `TAS_RESP_ERR);
		// Slave DSP A, tristate on, tx in slot 1, rx in slot 0.
		wr(`TAS_OFF_CTRL, 32'h0000_0040);
		wr(`TAS_OFF_FRAME, 32'h0010_0808);
		wr(`TAS_OFF_TXSLOT, 32'h1);
		wr(`TAS_OFF_TXD0, 32'h0000_003d);
		wr(`TAS_OFF_CHEN, 32'h0101);
		prt_run <= 1'b1;
		repeat (600) @(posedge clk_sys_i);
		chk(cap[7:0], txw);
		chk(cap_oe, 16'h00ff);
		rdc(`TAS_OFF_RXD0, 32'hffff_ffa5, `TAS_RESP_OK);
		wr(`TAS_OFF_CTRL, 32'h0);
		repeat (300) @(posedge clk_sys_i);
		chk({cap[15:8], cap_oe}, 24'h00ffff);
		prt_run <= 1'b0;
		repeat (20) @(posedge clk_sys_i);
		// Left-justified as slave is refused.
		wr(`TAS_OFF_CTRL, 32'h0000_0030);
		rd(`TAS_OFF_STATUS);
		chk({rd_q[1], bclk_oe_o, serial_data_out_oe_o}, 3'b100);
		wr(`TAS_OFF_TXSLOT, 32'h0);
		// Halves of nine bit clocks leave room for the delayed I2S LSB.
		wr(`TAS_OFF_FRAME, 32'h0012_0808);
		mstr(32'h0000_0013, 1'b1, 1);
		mstr(32'h0000_0023, 1'b0, 2);
		wr(`TAS_OFF_CHEN, 32'h0);
		repeat (40) @(posedge clk_sys_i);
		chk({bclk_oe_o, frame_oe_o, serial_data_out_oe_o}, 3'b000);
		end_of_test;
	end
endmodule : tas_port_test
